/* rtl/ccpc_pkg.sv */
// Package with modes, channel configuration and reset constants of the capture/compare/PWM counter.
package ccpc_pkg;

	// Operating mode of one channel.
	typedef enum logic [1:0] {
		CCPC_MODE_CAPTURE,
		CCPC_MODE_COMPARE,
		CCPC_MODE_PWM
	} ccpc_mode_t;

	// Capture edge selection codes.
	localparam logic [1:0] CCPC_EDGE_RISE = 2'h0;
	localparam logic [1:0] CCPC_EDGE_FALL = 2'h1;
	localparam logic [1:0] CCPC_EDGE_BOTH = 2'h2;

	// Static configuration of one channel.
	typedef struct packed {
		logic chEnable;
		ccpc_mode_t mode;
		logic [1:0] captureEdge;
		logic deadTimeEnable;
	} ccpc_ch_cfg_t;

	// Event pulses of one channel toward the event routing network.
	typedef struct packed {
		logic captureEvt;
		logic compareEvt;
	} ccpc_ch_evt_t;

	// Reset values and capture synchroniser depth.
	localparam logic CCPC_OUT_RESET = 1'b0;
	localparam logic CCPC_OUTN_RESET = 1'b0;
	localparam int CCPC_SYNC_STAGES = 3;

endpackage : ccpc_pkg

/* rtl/ccpc_channel.sv */
// One compare/capture channel with optional dead-time insertion on its PWM output pair.
`timescale 1ns/1ns
module ccpc_channel #(
	parameter int CNT_W = 16,
	parameter bit DT_PRESENT = 1'b0,
	parameter int DT_W = 8
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Counter state.
	input wire logic [CNT_W-1:0] count,
	input wire logic countTick,
	input wire logic countWrap,
	// Configuration and compare value.
	input wire ccpc_pkg::ccpc_ch_cfg_t cfg,
	input wire logic compareWrite,
	input wire logic [CNT_W-1:0] compareData,
	input wire logic [DT_W-1:0] deadTimeLen,
	// Filtered capture input level.
	input wire logic captureLevel,
	// Results.
	output logic [CNT_W-1:0] captureValue,
	output ccpc_pkg::ccpc_ch_evt_t events,
	output logic outP,
	output logic outN
);

	logic [CNT_W-1:0] captureValue_reg, captureValue_next;
	logic [CNT_W-1:0] compareBuf_reg, compareBuf_next;
	logic [CNT_W-1:0] compareAct_reg, compareAct_next;
	logic capturePrev_reg, capturePrev_next;
	logic rawPrev_reg, rawPrev_next;
	logic [DT_W-1:0] deadCnt_reg, deadCnt_next;
	logic outP_reg, outP_next;
	logic outN_reg, outN_next;
	ccpc_pkg::ccpc_ch_evt_t events_reg, events_next;
	logic edgeHit;
	logic raw;
	logic useDead;

	// Next-state logic for capture, compare buffering, output level and dead time.
	always_comb
	begin
		captureValue_next = captureValue_reg;
		compareBuf_next = compareBuf_reg;
		compareAct_next = compareAct_reg;
		capturePrev_next = captureLevel;
		events_next = '0;
		edgeHit = 1'b0;
		raw = 1'b0;
		useDead = DT_PRESENT && cfg.deadTimeEnable;
		deadCnt_next = deadCnt_reg;
		case (cfg.captureEdge)
			ccpc_pkg::CCPC_EDGE_RISE: edgeHit = captureLevel && !capturePrev_reg;
			ccpc_pkg::CCPC_EDGE_FALL: edgeHit = !captureLevel && capturePrev_reg;
			ccpc_pkg::CCPC_EDGE_BOTH: edgeHit = captureLevel != capturePrev_reg;
			default: edgeHit = 1'b0;
		endcase
		// Software writes land in the buffer; PWM takes them only at wrap so a period is never torn.
		if (compareWrite)
		begin
			compareBuf_next = compareData;
		end
		if (cfg.chEnable)
		begin
			case (cfg.mode)
				ccpc_pkg::CCPC_MODE_CAPTURE:
				begin
					if (edgeHit)
					begin
						captureValue_next = count;
						events_next.captureEvt = 1'b1;
					end
				end
				ccpc_pkg::CCPC_MODE_COMPARE:
				begin
					compareAct_next = compareWrite ? compareData : compareBuf_reg;
					raw = count >= compareAct_reg;
					events_next.compareEvt = countTick && (count == compareAct_reg);
				end
				ccpc_pkg::CCPC_MODE_PWM:
				begin
					if (countWrap)
					begin
						compareAct_next = compareBuf_next;
					end
					raw = count < compareAct_reg;
					events_next.compareEvt = countTick && (count == compareAct_reg);
				end
				default: raw = 1'b0;
			endcase
		end
		rawPrev_next = raw;
		// A level change starts a gap in which both outputs stay low.
		if (useDead && (raw != rawPrev_reg))
		begin
			deadCnt_next = deadTimeLen;
		end
		else if (deadCnt_reg != '0)
		begin
			deadCnt_next = deadCnt_reg - 1'b1;
		end
		if (!useDead)
		begin
			deadCnt_next = '0;
			outP_next = raw;
			outN_next = !raw && cfg.chEnable;
		end
		else
		begin
			outP_next = raw && (deadCnt_next == '0) && (raw == rawPrev_reg);
			// A disabled channel keeps both sides low, even with dead time switched on.
			outN_next = !raw && cfg.chEnable && (deadCnt_next == '0) && (raw == rawPrev_reg);
		end
	end

	// State registers.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			captureValue_reg <= '0;
			compareBuf_reg <= '0;
			compareAct_reg <= '0;
			capturePrev_reg <= 1'b0;
			rawPrev_reg <= 1'b0;
			deadCnt_reg <= '0;
			outP_reg <= ccpc_pkg::CCPC_OUT_RESET;
			outN_reg <= ccpc_pkg::CCPC_OUTN_RESET;
			events_reg <= '0;
		end
		else
		begin
			captureValue_reg <= captureValue_next;
			compareBuf_reg <= compareBuf_next;
			compareAct_reg <= compareAct_next;
			capturePrev_reg <= capturePrev_next;
			rawPrev_reg <= rawPrev_next;
			deadCnt_reg <= deadCnt_next;
			outP_reg <= outP_next;
			outN_reg <= outN_next;
			events_reg <= events_next;
		end
	end

	assign captureValue = captureValue_reg;
	assign events = events_reg;
	assign outP = outP_reg;
	assign outN = outN_reg;

endmodule : ccpc_channel

/* rtl/ccpc_counter_unit.sv */
// Top of the capture/compare/PWM counter unit: free-running counter, input synchronisers and channels.
`timescale 1ns/1ns
// Summary of operation
// - Narrow build uses a 16-bit counter with up to four channels on it.
// - Wide build is identical except counter and channel values are 32 bits.
// - Each channel runs in exactly one mode: capture, compare or PWM.
// - Capture stores the counter value when the selected input edge arrives.
// - Compare output shows whether the counter has reached the programmed threshold.
// - PWM output follows successive compare values, each taken at counter wrap.
// - Dead-time insertion exists only in the first instance of each build.
// - Capture, compare and overflow events pulse out toward the event routing network.
module ccpc_counter_unit #(
	parameter int CNT_W = 16,
	parameter int NUM_CH = 4,
	parameter bit FIRST_INSTANCE = 1'b1,
	parameter int DT_W = 8
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Counter control.
	input wire logic countEnable,
	input wire logic countTick,
	input wire logic overflowClear,
	// Channel configuration.
	input wire ccpc_pkg::ccpc_ch_cfg_t [NUM_CH-1:0] chCfg,
	input wire logic [NUM_CH-1:0] compareWrite,
	input wire logic [NUM_CH-1:0][CNT_W-1:0] compareData,
	input wire logic [DT_W-1:0] deadTimeLen,
	// Capture pins.
	input wire logic [NUM_CH-1:0] capturePin,
	// Counter state.
	output logic [CNT_W-1:0] count,
	output logic overflowFlag,
	// Event routing outputs.
	output logic overflowEvt,
	output ccpc_pkg::ccpc_ch_evt_t [NUM_CH-1:0] chEvt,
	// Channel results.
	output logic [NUM_CH-1:0][CNT_W-1:0] captureValue,
	output logic [NUM_CH-1:0] chOut,
	output logic [NUM_CH-1:0] chOutN
);

	localparam logic [CNT_W-1:0] CNT_MAX = '1;

	logic [CNT_W-1:0] count_reg, count_next;
	logic overflowFlag_reg, overflowFlag_next;
	logic overflowEvt_reg, overflowEvt_next;
	logic [NUM_CH-1:0] sync1_reg, sync2_reg, sync3_reg;
	logic [NUM_CH-1:0] capLevel_reg, capLevel_next;
	logic step;
	logic wrap;

	// Counter next value, overflow pulse and sticky flag; a new overflow beats a clear in the same cycle.
	always_comb
	begin
		step = countEnable && countTick;
		wrap = step && (count_reg == CNT_MAX);
		count_next = count_reg;
		if (step)
		begin
			count_next = wrap ? '0 : count_reg + 1'b1;
		end
		overflowEvt_next = wrap;
		overflowFlag_next = overflowFlag_reg;
		if (overflowClear)
		begin
			overflowFlag_next = 1'b0;
		end
		if (wrap)
		begin
			overflowFlag_next = 1'b1;
		end
	end

	// Capture level is accepted only once the second and third stages agree, filtering one-cycle glitches.
	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			capLevel_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : capLevel_reg[i];
		end
	end

	// Counter and synchroniser registers.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_reg <= '0;
			overflowFlag_reg <= 1'b0;
			overflowEvt_reg <= 1'b0;
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			capLevel_reg <= '0;
		end
		else
		begin
			count_reg <= count_next;
			overflowFlag_reg <= overflowFlag_next;
			overflowEvt_reg <= overflowEvt_next;
			sync1_reg <= capturePin;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			capLevel_reg <= capLevel_next;
		end
	end

	// One channel per compare/capture slot; dead time is built only into the first instance.
	for (genvar g = 0; g < NUM_CH; g++)
	begin : gen_ch
		ccpc_channel #(
			.CNT_W(CNT_W),
			.DT_PRESENT(FIRST_INSTANCE),
			.DT_W(DT_W)
		) u_ch (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.count(count_reg),
			.countTick(step),
			.countWrap(wrap),
			.cfg(chCfg[g]),
			.compareWrite(compareWrite[g]),
			.compareData(compareData[g]),
			.deadTimeLen(deadTimeLen),
			.captureLevel(capLevel_reg[g]),
			.captureValue(captureValue[g]),
			.events(chEvt[g]),
			.outP(chOut[g]),
			.outN(chOutN[g])
		);
	end

	assign count = count_reg;
	assign overflowFlag = overflowFlag_reg;
	assign overflowEvt = overflowEvt_reg;

endmodule : ccpc_counter_unit

/* dv/ccpc_counter_unit_chk.sv */
// Checker of the counter unit top ports.
`timescale 1ns/1ns
module ccpc_counter_unit_chk #(
	parameter int CNT_W = 16,
	parameter int NUM_CH = 4
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Inputs.
	input wire logic countEnable,
	input wire logic countTick,
	input wire logic overflowClear,
	input wire ccpc_pkg::ccpc_ch_cfg_t [NUM_CH-1:0] chCfg,
	// Outputs.
	input wire logic [CNT_W-1:0] count,
	input wire logic overflowFlag,
	input wire logic overflowEvt,
	input wire ccpc_pkg::ccpc_ch_evt_t [NUM_CH-1:0] chEvt,
	input wire logic [NUM_CH-1:0][CNT_W-1:0] captureValue,
	input wire logic [NUM_CH-1:0] chOut,
	input wire logic [NUM_CH-1:0] chOutN
);
	// A step needs enable and tick together, so a lone tick must not move the count.
	wire logic step = countEnable && countTick;
	wire logic atMax = &count;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	cnt_wrap_a: assert property (step && atMax |=> count == '0 && overflowEvt && overflowFlag)
		else $error("no wrap");
	cnt_step_a: assert property (step && !atMax |=> count == $past(count) + 1'b1)
		else $error("bad step");
	cnt_hold_a: assert property (!step |=> $stable(count))
		else $error("count moved");
	evt_pulse_a: assert property (overflowEvt |=> !overflowEvt)
		else $error("long event");
	flag_clr_a: assert property (overflowClear && !(step && atMax) |=> !overflowFlag)
		else $error("flag kept");
	off_ch_a: assert property (!chCfg[3].chEnable [*2] |-> !chOut[3] && !chOutN[3])
		else $error("off drives");
	cap_val_a: assert property (chEvt[0].captureEvt |-> captureValue[0] == $past(count))
		else $error("bad capture");
	cap_mode_a: assert property (chCfg[1].mode != ccpc_pkg::CCPC_MODE_CAPTURE [*2] |-> !chEvt[1].captureEvt)
		else $error("stray capture");
	// Main scenarios reached.
	wrap_c: cover property (step && atMax);
	cap_c: cover property (chEvt[0].captureEvt);
	pwm_c: cover property (chOut[2]);
	dead_c: cover property (chCfg[1].deadTimeEnable && chCfg[1].chEnable && !chOut[1] && !chOutN[1]);
endmodule : ccpc_counter_unit_chk
bind ccpc_counter_unit ccpc_counter_unit_chk #(.CNT_W(CNT_W), .NUM_CH(NUM_CH)) chk (.*);

/* dv/ccpc_evt_partner.sv */
// Event partner: capture source and consumer of routed overflow events.
`timescale 1ns/1ns
module ccpc_evt_partner (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Bench request and unit event.
	input wire logic capFire,
	input wire logic overflowEvt,
	// Results.
	output logic [3:0] capturePin,
	output logic [7:0] ovfSeen
);
	// Only channel 0 has a source; idle pins stay low.
	assign capturePin = {3'h0, capFire};
	// Each routed pulse is one consumer action.
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			ovfSeen <= 8'h00;
		else if (overflowEvt)
			ovfSeen <= ovfSeen + 8'h01;
endmodule : ccpc_evt_partner

/* dv/ccpc_counter_unit_test.sv */
// Self-checking bench of the counter unit.
`timescale 1ns/1ns
module ccpc_counter_unit_test;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic countEnable = 1'b0;
	logic countTick = 1'b0;
	logic overflowClear = 1'b0;
	// Channel 0 capture on rise, 1 compare, 2 PWM, 3 off; no dead time.
	ccpc_pkg::ccpc_ch_cfg_t [3:0] chCfg = 24'h030a20;
	logic [3:0] compareWrite = 4'h0;
	logic [3:0][15:0] compareData = '0;
	logic [7:0] deadTimeLen = 8'h04;
	logic [3:0] capturePin;
	logic [15:0] count;
	logic overflowFlag;
	logic overflowEvt;
	ccpc_pkg::ccpc_ch_evt_t [3:0] chEvt;
	logic [3:0][15:0] captureValue;
	logic [3:0] chOut;
	logic [3:0] chOutN;
	logic [7:0] ovfSeen;
	logic capFire = 1'b0;
	int errors = 0;
	int cmp_count = 0;
	// Clock and instances.
	always #5 ref_clk = ~ref_clk;
	ccpc_counter_unit DUT (.*);
	ccpc_evt_partner partner (.*);
	task check(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			errors++;
			$display("wrong value %s exp %h seen %h", n, e, s);
		end
	endtask : check
	task summarize;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	// Bounded wait for a count value, sampled after the edge settles; running out counts as a mismatch.
	task waitc(input logic [15:0] v);
		for (int i = 0; i < 70000 && count !== v; i++)
			@(posedge ref_clk) #1;
		if (count !== v)
			errors++;
	endtask : waitc
	task t_compare;
		waitc(16'h0020);
		check("cmpLow", {chOut[1], chOutN[1]}, 2'h1);
		waitc(16'h0041);
		check("cmpEvt", chEvt[1].compareEvt, 1'b1);
		waitc(16'h0048);
		check("cmpHigh", chOut[1], 1'b1);
		check("offCh", {chOut[3], chOutN[3]}, 2'h0);
	endtask : t_compare
	// The pin rises one edge after count 0x48; three sync stages, the filter and the edge logic store 0x4d.
	task t_capture;
		@(posedge ref_clk) capFire <= 1'b1;
		for (int i = 0; i < 20 && chEvt[0].captureEvt !== 1'b1; i++)
			@(posedge ref_clk) #1;
		check("capVal", captureValue[0], 16'h004d);
		check("capEvt", chEvt[0].captureEvt, 1'b1);
		// Falling-edge capture: the pin drops six edges after the rise, so the stored value is 0x53.
		@(posedge ref_clk) capFire <= 1'b0;
		chCfg[0].captureEdge <= ccpc_pkg::CCPC_EDGE_FALL;
		@(posedge ref_clk) #1;
		for (int i = 0; i < 20 && chEvt[0].captureEvt !== 1'b1; i++)
			@(posedge ref_clk) #1;
		check("capFall", captureValue[0], 16'h0053);
	endtask : t_capture
	// The PWM threshold only takes effect at the wrap; a clear in the wrap cycle loses to the new overflow.
	task t_wrap;
		check("pwmOld", chOut[2], 1'b0);
		waitc(16'hfffe);
		@(posedge ref_clk) overflowClear <= 1'b1;
		@(posedge ref_clk) overflowClear <= 1'b0;
		#1 check("wrapCnt", count, 16'h0000);
		check("wrapEvt", {overflowEvt, overflowFlag}, 2'h3);
		waitc(16'h0080);
		check("pwmHigh", {chOut[2], chOutN[2]}, 2'h2);
		waitc(16'h0120);
		check("pwmLow", chOut[2], 1'b0);
		check("routed", ovfSeen, 8'h01);
	endtask : t_wrap
	task t_clear;
		@(posedge ref_clk) overflowClear <= 1'b1;
		@(posedge ref_clk) overflowClear <= 1'b0;
		#1 check("flagClr", overflowFlag, 1'b0);
	endtask : t_clear
	task t_hold;
		logic [15:0] v;
		@(posedge ref_clk) countEnable <= 1'b0;
		@(posedge ref_clk) #1 v = count;
		repeat (5) @(posedge ref_clk);
		#1 check("hold", count, v);
	endtask : t_hold
	// Dead time on channel 1 with the count held: the level change leaves both sides low for four cycles.
	task t_dead;
		@(posedge ref_clk) chCfg[1].deadTimeEnable <= 1'b1;
		@(posedge ref_clk) compareWrite <= 4'h2;
		compareData[1] <= 16'hffff;
		@(posedge ref_clk) compareWrite <= 4'h0;
		@(posedge ref_clk) #1 check("deadStart", {chOut[1], chOutN[1]}, 2'h0);
		repeat (3) @(posedge ref_clk);
		#1 check("deadGap", {chOut[1], chOutN[1]}, 2'h0);
		@(posedge ref_clk) #1 check("deadEnd", {chOut[1], chOutN[1]}, 2'h1);
	endtask : t_dead
	// Main sequence.
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		countEnable <= 1'b1;
		countTick <= 1'b1;
		compareData <= {16'h0000, 16'h0100, 16'h0040, 16'h0000};
		compareWrite <= 4'h6;
		@(posedge ref_clk) compareWrite <= 4'h0;
		t_compare;
		t_capture;
		t_wrap;
		t_clear;
		t_hold;
		t_dead;
		summarize;
	end
	// Watchdog: the run needs about 66000 cycles.
	initial
	begin
		#1000000;
		errors++;
		summarize;
	end
endmodule : ccpc_counter_unit_test
